// *** logic/pfm_pkg.sv ***
// constants, ball tables and register layout of the pad function multiplexer
package pfm_pkg;
	localparam int NUM_BALLS = 10;
	localparam int MODE_W    = 4;
	localparam int NUM_MODES = 16;

	// ball indices; the table entries below follow this order
	localparam int BALL_HOST_INT  = 0;
	localparam int BALL_SPIB_OUT  = 1;
	localparam int BALL_SPIB_IN   = 2;
	localparam int BALL_WARM      = 3;
	localparam int BALL_JTAG_CLK  = 4;
	localparam int BALL_JTAG_MODE = 5;
	localparam int BALL_JTAG_IN   = 6;
	localparam int BALL_JTAG_OUT  = 7;
	localparam int BALL_SYNC_IN   = 8;
	localparam int BALL_SYNC_OUT  = 9;

	// byte addresses of the ball_select_register of each ball
	localparam logic [31:0] HOST_INTERRUPT_BALL_SELECT = 32'hFFFFEA00;
	localparam logic [31:0] SPIB_OUT_DATA_BALL_SELECT  = 32'hFFFFEA1C;
	localparam logic [31:0] SPIB_IN_DATA_BALL_SELECT   = 32'hFFFFEA20;
	localparam logic [31:0] WARM_RESTART_BALL_SELECT   = 32'hFFFFEA48;
	localparam logic [31:0] JTAG_CLOCK_BALL_SELECT     = 32'hFFFFEA50;
	localparam logic [31:0] JTAG_MODE_BALL_SELECT      = 32'hFFFFEA54;
	localparam logic [31:0] JTAG_IN_BALL_SELECT        = 32'hFFFFEA58;
	localparam logic [31:0] JTAG_OUT_BALL_SELECT       = 32'hFFFFEA5C;
	localparam logic [31:0] SYNC_INPUT_BALL_SELECT     = 32'hFFFFEA6C;
	localparam logic [31:0] SYNC_OUTPUT_BALL_SELECT    = 32'hFFFFEA70;
	localparam logic [31:0] BALL_ADDR [0:NUM_BALLS-1] = '{
		HOST_INTERRUPT_BALL_SELECT, SPIB_OUT_DATA_BALL_SELECT, SPIB_IN_DATA_BALL_SELECT,
		WARM_RESTART_BALL_SELECT, JTAG_CLOCK_BALL_SELECT, JTAG_MODE_BALL_SELECT,
		JTAG_IN_BALL_SELECT, JTAG_OUT_BALL_SELECT, SYNC_INPUT_BALL_SELECT,
		SYNC_OUTPUT_BALL_SELECT};

	// register fields
	localparam int FUNC_SEL_LSB  = 0;
	localparam int PULL_OFF_BIT  = 8;
	localparam int PULL_UP_BIT   = 9;
	localparam logic [MODE_W-1:0] FUNC_SEL_RESET = 4'h1;

	// modes that exist on each ball, one bit per mode number
	localparam logic [15:0] MODE_VALID [0:NUM_BALLS-1] = '{
		16'h0047,  // host int: 0 gpio, 1 host_interrupt_out, 2 adc valid, 6 second_spi_select_one
		16'h0007,  // spib out: 0 gpio, 1 second_spi_out_data, 2 i2c data
		16'h0047,  // spib in: 0 gpio, 1 second_spi_in_data, 2 i2c clock, 6 signal_proc_serial_tx
		16'h0001,  // warm reset: 0 only
		16'h0107,  // jtag clock: 0 gpio, 1 clock, 2 main_serial_two_tx, 8 can-fd tx
		16'h0047,  // jtag mode: 0 gpio, 1 mode, 2 radar_subsys_serial_tx, 6 can-fd rx
		16'h0007,  // jtag in: 0 gpio, 1 data in, 2 main_serial_one_rx
		16'h02C7,  // jtag out: 0 gpio, 1 data out, 2/6/7 serial tx, 9 monitor_enable_low
		16'h02C3,  // sync in: 0 gpio, 1 sync in, 6 main_serial_two_rx, 7 monitor_mux_input, 9 sync out
		16'h0E03}; // sync out: 0 gpio, 1 sync out, 9 monitor_mux_input, 10/11 selects
	// modes that may drive the ball
	localparam logic [15:0] MODE_OUT [0:NUM_BALLS-1] = '{
		16'h0047, 16'h0007, 16'h0047, 16'h0001, 16'h0105,
		16'h0005, 16'h0001, 16'h00C7, 16'h0241, 16'h0C03};
	// modes that receive from the ball
	localparam logic [15:0] MODE_IN [0:NUM_BALLS-1] = '{
		16'h0041, 16'h0007, 16'h0007, 16'h0001, 16'h0003,
		16'h0043, 16'h0007, 16'h0201, 16'h00C3, 16'h0E01};

	// per-ball pad attributes, one bit per ball index
	localparam logic [NUM_BALLS-1:0] HAS_PULL      = 10'h377; // warm reset and jtag out have none
	localparam logic [NUM_BALLS-1:0] PULL_UP_RESET = 10'h046;
	localparam logic [NUM_BALLS-1:0] OE_RESET      = 10'h080; // only jtag out drives at reset
	localparam logic [NUM_BALLS-1:0] OPEN_DRAIN    = 10'h008;

	// balls sampled for boot options while reset is released
	localparam int BOOT_BIT0_BALL = BALL_JTAG_OUT;
	localparam int BOOT_BIT1_BALL = BALL_SYNC_OUT;
endpackage

// *** logic/pfm_boot_latch.sv ***
// captures the boot option balls once, in the first cycle after reset release
`timescale 1ns/100ps
module pfm_boot_latch #(
	parameter int WIDTH = 2
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_sample,
	output logic      [WIDTH-1:0] o_boot_option,
	output logic                  o_boot_valid
);
	if (WIDTH < 1) begin : g_chk
		$error("pfm_boot_latch: WIDTH must be at least 1");
	end

	// the balls are still in their reset state in that cycle, so straps are clean
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_boot_valid  <= 1'b0;
			o_boot_option <= '0;
		end else if (!o_boot_valid) begin
			o_boot_valid  <= 1'b1;
			o_boot_option <= i_sample;
		end
	end
endmodule

// *** logic/pfm_pad_drive.sv ***
// registered pad stage of one ball: drive, enable, pull and open-drain handling
`timescale 1ns/100ps
module pfm_pad_drive #(
	parameter bit OPEN_DRAIN    = 1'b0,
	parameter bit OE_RESET      = 1'b0,
	parameter bit PULL_RESET    = 1'b0,
	parameter bit PULL_UP_RESET = 1'b0
) (
	input  wire logic i_ref_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_out,
	input  wire logic i_oe,
	input  wire logic i_pull_en,
	input  wire logic i_pull_up,
	output logic      o_pad_out,
	output logic      o_pad_oe,
	output logic      o_pull_en,
	output logic      o_pull_up
);
	logic next_out;
	logic next_oe;

	// open drain only ever pulls low; a high level releases the ball
	assign next_out = OPEN_DRAIN ? 1'b0 : i_out;
	assign next_oe  = OPEN_DRAIN ? (i_oe & ~i_out) : i_oe;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_pad_out <= 1'b0;
			o_pad_oe  <= OE_RESET;
			o_pull_en <= PULL_RESET;
			o_pull_up <= PULL_UP_RESET;
		end else begin
			o_pad_out <= next_out;
			o_pad_oe  <= next_oe;
			o_pull_en <= i_pull_en;
			o_pull_up <= i_pull_up;
		end
	end
endmodule

// *** logic/pfm_top.sv ***
// pad function multiplexer: ball select registers, per-ball mode routing, pads
// Functional notes
// - the mode of each ball is the lowest four bits of its ball select register.
// - a ball is joined to exactly the internal signal whose mode number matches its register.
// - software turns each ball's pull on or off, and a ball without a pull never has one.
// - the spi-b input data ball offers gpio, spi-b in data, i2c clock and dsp serial tx, reset disabled with pull-up.
// - the spi-b output data ball offers gpio, spi-b out data and i2c data, reset disabled with pull-up.
// - the host interrupt ball offers gpio, host interrupt, adc valid and chip select one, reset with pull-down.
// - the sync input ball offers gpio, sync in, serial two rx, monitor mux in and sync out, reset with pull-down.
// - the sync output ball samples boot bit 1 at power-up, then offers gpio, sync out, monitor and selects.
// - the jtag clock ball offers gpio, clock, serial two tx and can-fd tx, reset as input with pull-down.
// - the jtag data in ball offers gpio, data in and serial one rx, reset as input with pull-up.
// - the jtag data out ball samples boot bit 0, resets driving without pull, and offers six functions.
// - the jtag mode ball offers gpio, mode, radar serial tx and can-fd rx, reset as input with pull-down.
// - the warm reset ball offers only its reset function and resets as a released open-drain input.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module pfm_top #(
	parameter int NUM_BALLS = pfm_pkg::NUM_BALLS,
	parameter int MODE_W    = pfm_pkg::MODE_W
) (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_sys_rst,
	// register port
	input  wire logic [31:0]                   i_reg_addr,
	input  wire logic [31:0]                   i_reg_wdata,
	input  wire logic                          i_reg_wr,
	input  wire logic                          i_reg_rd,
	output logic      [31:0]                   o_reg_rdata,
	// core side, index ball*16+mode
	input  wire logic [NUM_BALLS*16-1:0]       i_core_out,
	input  wire logic [NUM_BALLS*16-1:0]       i_core_oe,
	output logic      [NUM_BALLS*16-1:0]       o_core_in,
	// ball side
	input  wire logic [NUM_BALLS-1:0]          i_pad_in,
	output logic      [NUM_BALLS-1:0]          o_pad_out,
	output logic      [NUM_BALLS-1:0]          o_pad_oe,
	output logic      [NUM_BALLS-1:0]          o_pull_en,
	output logic      [NUM_BALLS-1:0]          o_pull_up,
	// straps
	output logic      [1:0]                    o_boot_option,
	output logic                               o_boot_valid
);
	localparam int NM = pfm_pkg::NUM_MODES;

	// the tables in the package are sized for exactly this ball set and mode width
	if (NUM_BALLS != pfm_pkg::NUM_BALLS || MODE_W != pfm_pkg::MODE_W) begin : g_chk
		$error("pfm_top: NUM_BALLS and MODE_W must match the ball tables");
	end

	// address decode, used by both the write and the read path
	function automatic logic [NUM_BALLS-1:0] pfm_decode(input logic [31:0] addr);
		logic [NUM_BALLS-1:0] hit;
		hit = '0;
		for (int b = 0; b < NUM_BALLS; b++) begin
			hit[b] = (addr == pfm_pkg::BALL_ADDR[b]);
		end
		return hit;
	endfunction

	logic [NUM_BALLS-1:0] addr_hit;
	logic [NUM_BALLS-1:0] wr_hit;
	logic [NUM_BALLS-1:0] rd_hit;

	// unmapped addresses hit nothing: writes vanish and reads return zero
	assign addr_hit = pfm_decode(i_reg_addr);
	assign wr_hit   = i_reg_wr ? addr_hit : '0;
	assign rd_hit   = i_reg_rd ? addr_hit : '0;

	// per-ball register fields and routing
	logic [MODE_W-1:0]    func_sel   [NUM_BALLS];
	logic [NUM_BALLS-1:0] pull_off;
	logic [NUM_BALLS-1:0] pull_up;
	logic [NUM_BALLS-1:0] configured;
	logic [31:0]          rd_word    [NUM_BALLS];
	logic [NUM_BALLS-1:0] sel_out;
	logic [NUM_BALLS-1:0] sel_oe;
	logic [NUM_BALLS-1:0] pad_oe_now;
	logic [NUM_BALLS-1:0] pull_en_now;

	genvar gb;
	genvar gm;
	for (gb = 0; gb < NUM_BALLS; gb++) begin : g_ball
		localparam logic [15:0] VALID   = pfm_pkg::MODE_VALID[gb];
		localparam logic [15:0] OUT_OK  = pfm_pkg::MODE_OUT[gb];
		localparam logic [15:0] IN_OK   = pfm_pkg::MODE_IN[gb];
		localparam bit          HAS_PL  = pfm_pkg::HAS_PULL[gb];
		localparam bit          PL_UP   = pfm_pkg::PULL_UP_RESET[gb];
		localparam bit          OE_RST  = pfm_pkg::OE_RESET[gb];
		localparam bit          OD      = pfm_pkg::OPEN_DRAIN[gb];

		logic [NM-1:0] mode_hot;
		logic [NM-1:0] ball_out;
		logic [NM-1:0] ball_oe;

		// ball select register; pull bits only exist where the ball has a pull
		always_ff @(posedge i_ref_clk) begin
			if (i_sys_rst) begin
				func_sel[gb]   <= pfm_pkg::FUNC_SEL_RESET;
				pull_off[gb]   <= ~HAS_PL;
				pull_up[gb]    <= PL_UP;
				configured[gb] <= 1'b0;
			end else if (wr_hit[gb]) begin
				func_sel[gb]   <= i_reg_wdata[pfm_pkg::FUNC_SEL_LSB +: MODE_W];
				pull_off[gb]   <= HAS_PL ? i_reg_wdata[pfm_pkg::PULL_OFF_BIT] : 1'b1;
				pull_up[gb]    <= HAS_PL ? i_reg_wdata[pfm_pkg::PULL_UP_BIT] : 1'b0;
				configured[gb] <= 1'b1;
			end
		end

		// reserved bits read as zero; a ball without a pull reads its pull disable bit as one
		always_comb begin
			rd_word[gb] = '0;
			rd_word[gb][pfm_pkg::FUNC_SEL_LSB +: MODE_W] = func_sel[gb];
			rd_word[gb][pfm_pkg::PULL_OFF_BIT] = pull_off[gb];
			rd_word[gb][pfm_pkg::PULL_UP_BIT]  = pull_up[gb];
		end

		// one-hot of the selected mode; a mode the ball lacks selects nothing
		for (gm = 0; gm < NM; gm++) begin : g_mode
			assign mode_hot[gm] = VALID[gm] && (func_sel[gb] == MODE_W'(gm));
			assign ball_out[gm] = mode_hot[gm] & OUT_OK[gm] & i_core_out[gb*NM+gm];
			assign ball_oe[gm]  = mode_hot[gm] & OUT_OK[gm] & i_core_oe[gb*NM+gm];
		end

		assign sel_out[gb] = |ball_out;
		assign sel_oe[gb]  = |ball_oe;

		// until software first writes the register the ball holds its reset direction;
		// this keeps a peripheral on the reset mode from driving a ball meant as input
		assign pad_oe_now[gb]  = configured[gb] ? sel_oe[gb] : OE_RST;
		assign pull_en_now[gb] = HAS_PL & ~pull_off[gb];

		// receive path: only the selected input-capable mode sees the ball
		always_ff @(posedge i_ref_clk) begin
			if (i_sys_rst) begin
				o_core_in[gb*NM +: NM] <= '0;
			end else begin
				o_core_in[gb*NM +: NM] <= (mode_hot & IN_OK) & {NM{i_pad_in[gb]}};
			end
		end

		pfm_pad_drive #(
			.OPEN_DRAIN    (OD),
			.OE_RESET      (OE_RST),
			.PULL_RESET    (HAS_PL),
			.PULL_UP_RESET (PL_UP)
		) u_pad (
			.i_ref_clk (i_ref_clk),
			.i_sys_rst (i_sys_rst),
			.i_out     (sel_out[gb]),
			.i_oe      (pad_oe_now[gb]),
			.i_pull_en (pull_en_now[gb]),
			.i_pull_up (pull_up[gb]),
			.o_pad_out (o_pad_out[gb]),
			.o_pad_oe  (o_pad_oe[gb]),
			.o_pull_en (o_pull_en[gb]),
			.o_pull_up (o_pull_up[gb])
		);
	end

	// read select: the decode is one-hot, so an or-reduction suffices
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		for (int b = 0; b < NUM_BALLS; b++) begin
			rd_mux = rd_mux | (rd_hit[b] ? rd_word[b] : 32'h00000000);
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= '0;
		end else begin
			o_reg_rdata <= rd_mux;
		end
	end

	// boot straps come from the jtag out and sync out balls
	logic [1:0] boot_sample;
	assign boot_sample = {i_pad_in[pfm_pkg::BOOT_BIT1_BALL], i_pad_in[pfm_pkg::BOOT_BIT0_BALL]};

	pfm_boot_latch #(
		.WIDTH (2)
	) u_boot (
		.i_ref_clk     (i_ref_clk),
		.i_sys_rst     (i_sys_rst),
		.i_sample      (boot_sample),
		.o_boot_option (o_boot_option),
		.o_boot_valid  (o_boot_valid)
	);
endmodule

// *** bench/pfm_top_sva.sv ***
// port level checker of the pad function multiplexer
`timescale 1ns/100ps
module pfm_top_sva #(
	parameter int NUM_BALLS = pfm_pkg::NUM_BALLS,
	parameter int MODE_W    = pfm_pkg::MODE_W
) (
	input wire logic                    i_ref_clk,
	input wire logic                    i_sys_rst,
	input wire logic [31:0]             i_reg_addr,
	input wire logic [31:0]             i_reg_wdata,
	input wire logic                    i_reg_wr,
	input wire logic                    i_reg_rd,
	input wire logic [31:0]             o_reg_rdata,
	input wire logic [NUM_BALLS*16-1:0] i_core_out,
	input wire logic [NUM_BALLS*16-1:0] i_core_oe,
	input wire logic [NUM_BALLS*16-1:0] o_core_in,
	input wire logic [NUM_BALLS-1:0]    i_pad_in,
	input wire logic [NUM_BALLS-1:0]    o_pad_out,
	input wire logic [NUM_BALLS-1:0]    o_pad_oe,
	input wire logic [NUM_BALLS-1:0]    o_pull_en,
	input wire logic [NUM_BALLS-1:0]    o_pull_up,
	input wire logic [1:0]              o_boot_option,
	input wire logic                    o_boot_valid
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	// first edge that samples reset low
	sequence s_release;
		$past(i_sys_rst) && !i_sys_rst;
	endsequence
	// pads must come out of reset in their documented direction and pull
	reset_state_a: assert property (s_release |-> o_pad_oe == pfm_pkg::OE_RESET && o_pull_en == pfm_pkg::HAS_PULL
		&& o_pull_up == pfm_pkg::PULL_UP_RESET && o_core_in == '0) else $error("pad reset state wrong");
	boot_capture_a: assert property (s_release |=> o_boot_valid
		&& o_boot_option == {$past(i_pad_in[9]), $past(i_pad_in[7])}) else $error("boot straps not captured");
	boot_hold_a: assert property (o_boot_valid |=> o_boot_valid && $stable(o_boot_option))
		else $error("boot straps changed");
	rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0) else $error("read data without read");
	rsvd_zero_a: assert property (i_reg_rd |=> o_reg_rdata[31:10] == 22'h0 && o_reg_rdata[7:4] == 4'h0)
		else $error("unused register bits read nonzero");
	no_pull_a: assert property (!o_pull_en[3] && !o_pull_en[7]) else $error("pull on a ball without one");
	warm_low_a: assert property (o_pad_out[3] == 1'b0) else $error("open drain ball driven high");
	warm_drain_a: assert property (o_pad_oe[3] |-> $past(i_core_oe[48]) && !$past(i_core_out[48]))
		else $error("open drain ball enabled wrongly");
	// input modes outside the ball list or more than one mode never receive
	for (genvar b = 0; b < NUM_BALLS; b++) begin : g_ball
		core_in_mask_a: assert property ($onehot0(o_core_in[b*16 +: 16])
			&& (o_core_in[b*16 +: 16] & ~pfm_pkg::MODE_IN[b]) == 16'h0) else $error("ball input routed wrongly");
	end
endmodule
bind pfm_top pfm_top_sva #(.NUM_BALLS(NUM_BALLS), .MODE_W(MODE_W)) u_sva (.i_ref_clk(i_ref_clk),
	.i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
	.o_core_in(o_core_in), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
	.o_pull_en(o_pull_en), .o_pull_up(o_pull_up), .o_boot_option(o_boot_option), .o_boot_valid(o_boot_valid));

// *** bench/test_pfm_top.sv ***
// self-checking bench of the pad function multiplexer
`timescale 1ns/100ps
module test_pfm_top;
	logic         i_ref_clk   = 1'b0;
	logic         i_sys_rst   = 1'b1;
	logic [31:0]  i_reg_addr  = 32'h0;
	logic [31:0]  i_reg_wdata = 32'h0;
	logic         i_reg_wr    = 1'b0;
	logic         i_reg_rd    = 1'b0;
	logic [159:0] i_core_out  = '0;
	logic [159:0] i_core_oe   = '0;
	logic [9:0]   i_pad_in    = 10'h2A5;
	logic [31:0]  o_reg_rdata;
	logic [159:0] o_core_in;
	logic [9:0]   o_pad_out, o_pad_oe, o_pull_en, o_pull_up;
	logic [1:0]   o_boot_option;
	logic         o_boot_valid;
	logic [31:0]  rnd = 32'h1EF4;
	int           miscompares = 0;
	int           samples_checked = 0;
	int           cycles = 0;

	pfm_top DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_core_out(i_core_out),
		.i_core_oe(i_core_oe), .o_core_in(o_core_in), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
		.o_pad_oe(o_pad_oe), .o_pull_en(o_pull_en), .o_pull_up(o_pull_up), .o_boot_option(o_boot_option),
		.o_boot_valid(o_boot_valid));

	always #4 i_ref_clk = ~i_ref_clk;
	// a hang past the ceiling closes the run as a failure
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction
	// readback: balls without a pull hold pull disabled and pull down
	function automatic logic [31:0] exp_reg(input int b, input logic [31:0] d);
		logic h;
		h = pfm_pkg::HAS_PULL[b];
		return {22'h0, h & d[9], ~h | d[8], 4'h0, d[3:0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_wr <= 1'b0;
	endtask
	// read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, o_reg_rdata);
	endtask
	// random drive of every core function and ball level
	task automatic draw();
		logic [159:0] a, o;
		for (int k = 0; k < 5; k++) begin
			rnd = lfsr(rnd);
			a[k*32 +: 32] = rnd;
			rnd = lfsr(rnd);
			o[k*32 +: 32] = rnd;
		end
		i_core_out <= a;
		i_core_oe <= o;
		i_pad_in <= rnd[9:0];
	endtask
	task automatic rst_chk();
		i_sys_rst <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_ref_clk);
		#1 chk("pad_oe", 32'(pfm_pkg::OE_RESET), 32'(o_pad_oe));
		chk("pull_en", 32'(pfm_pkg::HAS_PULL), 32'(o_pull_en));
		chk("pull_up", 32'(pfm_pkg::PULL_UP_RESET), 32'(o_pull_up));
		chk("boot", {29'h0, 1'b1, i_pad_in[9], i_pad_in[7]}, {29'h0, o_boot_valid, o_boot_option});
		// after reset the pull disable bit is clear wherever the ball has a pull
		for (int b = 0; b < 10; b++)
			rd_chk(pfm_pkg::BALL_ADDR[b], exp_reg(b, {22'h0, pfm_pkg::PULL_UP_RESET[b], 9'h001}));
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		logic [31:0] d;
		logic        eoe, eout, pen;
		logic [15:0] ein;
		rst_chk();
		// every mode number on every ball, reserved bits random
		for (int b = 0; b < 10; b++) begin
			for (int m = 0; m < 16; m++) begin
				rnd = lfsr(rnd);
				d = {rnd[31:4], 4'(m)};
				draw();
				wr(pfm_pkg::BALL_ADDR[b], d);
				@(posedge i_ref_clk);
				#1 eoe = pfm_pkg::MODE_OUT[b][m] & i_core_oe[b*16+m];
				eout = i_core_out[b*16+m];
				if (b == 3) begin
					eoe = eoe & ~eout;
					eout = 1'b0;
				end
				ein = pfm_pkg::MODE_IN[b][m] ? (16'h0001 << m) & {16{i_pad_in[b]}} : 16'h0;
				pen = pfm_pkg::HAS_PULL[b] & ~d[8];
				chk("pad_oe", 32'(eoe), 32'(o_pad_oe[b]));
				if (eoe || b == 3)
					chk("pad_out", 32'(eout), 32'(o_pad_out[b]));
				chk("core_in", 32'(ein), 32'(o_core_in[b*16 +: 16]));
				chk("pull_en", 32'(pen), 32'(o_pull_en[b]));
				if (pen)
					chk("pull_up", 32'(d[9]), 32'(o_pull_up[b]));
				rd_chk(pfm_pkg::BALL_ADDR[b], exp_reg(b, d));
			end
		end
		// unmapped register: write lost, read zero
		wr(32'hFFFFEA04, 32'h0000030F);
		rd_chk(32'hFFFFEA04, 32'h0);
		// the lost write must not have reached the sync output ball register either
		rd_chk(pfm_pkg::BALL_ADDR[9], exp_reg(9, d));
		rst_chk();
		print_verdict();
	end
endmodule
